/* core/clk_filt_pkg.sv */
// constants and carriers for the converter clock and filter control block
package clk_filt_pkg;
  localparam int unsigned OSC_HZ         = 16000000;
  localparam int unsigned SYS_HZ         = 250000000;
  localparam int unsigned SINC5_RATE_SPS = 250000;
  localparam int unsigned SETTLE_ONCE_SPS = 10000;
  localparam int unsigned SINC3_SETTLE_N = 3;
  localparam int unsigned DIRECT_MULT    = 32;
  localparam int unsigned MOD_DIV        = 2;
  // master clock cycles per sinc5 output (mclk/2 modulator, /32 in sinc5)
  localparam int unsigned SINC5_MCLK     = OSC_HZ / SINC5_RATE_SPS;
  // system cycles per half period of the internal 16 MHz source, rounded down
  localparam int unsigned OSC_HALF_CYC   = SYS_HZ / (2 * OSC_HZ) < 1 ? 1 : SYS_HZ / (2 * OSC_HZ);
  // sinc1 decimation at or above which the sinc5+sinc1 path settles at once
  localparam int unsigned SINC1_SETTLE_MIN = SINC5_RATE_SPS / SETTLE_ONCE_SPS;

  // clock source select field
  localparam logic [1:0] CLK_SRC_INT     = 2'h0;
  localparam logic [1:0] CLK_SRC_INT_OUT = 2'h1;
  localparam logic [1:0] CLK_SRC_EXT     = 2'h2;
  localparam logic [1:0] CLK_SRC_XTAL    = 2'h3;
  localparam logic [1:0] CLK_SRC_RST     = CLK_SRC_INT;

  // filter type field
  localparam logic [1:0] FILT_SINC5_SINC1 = 2'h0;
  localparam logic [1:0] FILT_ENHANCED    = 2'h2;
  localparam logic [1:0] FILT_SINC3       = 2'h3;

  // filter_config layout
  localparam int unsigned FC_DIRECT_BIT = 15;
  localparam int unsigned FC_TYPE_LSB   = 5;
  localparam int unsigned FC_RATE_LSB   = 0;
  localparam int unsigned FC_RATE_W     = 5;
  localparam logic [15:0] FC_RST        = 16'h0000;

  // register bus
  localparam logic [3:0] ADDR_MODE    = 4'h0;
  localparam logic [3:0] ADDR_FC0     = 4'h1;
  localparam logic [3:0] ADDR_FC1     = 4'h2;
  localparam logic [3:0] ADDR_CHAN    = 4'h3;
  localparam logic [3:0] ADDR_STATUS  = 4'h4;
  localparam logic [3:0] ADDR_MASK    = 4'h5;
  localparam logic [3:0] ADDR_DATA    = 4'h6;
  localparam logic [3:0] ADDR_INFO    = 4'h7;
  localparam int unsigned MODE_SETTLE_BIT = 4;
  localparam int unsigned MODE_CLK_LSB    = 2;
  localparam int unsigned ST_RDY_BIT  = 0;
  localparam int unsigned ST_SRC_BIT  = 1;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic in;
    logic out;
    logic oe;
  } pin_t;
endpackage

/* core/clk_filt_ctrl.sv */
// master clock source selection and decimation filter rate/settling control
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
// Overview of operation
// - after reset the internal 16 MHz oscillator is the master clock.
// - a source setting drives the internal clock out on the clock pin.
// - external mode takes the clock pin edges as master clock.
// - three filter types: sinc5+sinc1, sinc3, enhanced 50/60 Hz.
// - each channel's conversion timing uses its own setup's filter type and rate; filter_type_o shows setup 0.
// - sinc5 output fixed at 250 kSPS; sinc1 decimation sets final rate.
// - sinc5+sinc1 at 10 kSPS or lower settles in one conversion.
// - sinc3 settling is three output periods.
// - direct-decimation bit remaps filter config; other options ignored.
// - direct mode rate is modulator rate over 32 times config bits 14:0.
// - modulator runs at half the master clock.
// - settle-once mode stretches output period to the settling time.
// - settle-once has no effect on sinc5+sinc1 at 10 kSPS or lower.
// - without settle-once, sinc3 needs three conversions after a step.
// - in settle-once mode ready pulses at the reduced rate.
// - two-bit source select field; internal source after reset.
// - all rates scale with the master clock actually supplied.
module clk_filt_ctrl #(
  parameter int unsigned DATA_W = 24
) (
  input  wire logic                     clock_i,
  input  wire logic                     arst_n_i,
  input  wire clk_filt_pkg::bus_req_t   bus_i,
  output logic [15:0]                   rdata_o,
  input  wire logic                     clock_io_pin_i,
  output logic                          clock_io_pin_o,
  output logic                          clock_io_pin_oe_o,
  input  wire logic                     crystal_input_pin_i,
  input  wire logic [DATA_W-1:0]        sample_i,
  output logic                          modulator_rate_o,
  output logic [1:0]                    filter_type_o,
  output logic                          data_ready_o,
  output logic [DATA_W-1:0]             data_o,
  output logic                          irq_o
);
  import clk_filt_pkg::*;

  typedef struct packed {
    logic [2:0]        ext_sync;
    logic [2:0]        xtal_sync;
    logic              ext_lvl;
    logic              xtal_lvl;
    logic [7:0]        osc_cnt;
    logic              osc_clk;
    logic              mclk_div;
    logic [1:0]        clk_src;
    logic              settle_once_mode;
    logic [15:0]       filter_config0;
    logic [15:0]       filter_config1;
    logic              chan;
    logic [20:0]       mclk_cnt;
    logic [1:0]        settle_cnt;
    logic [1:0]        status;
    logic [1:0]        mask;
    logic [DATA_W-1:0] data;
    logic              ready;
    logic              mod_clk;
    logic [15:0]       rdata;
    logic              irq;
    logic              pin_out;
    logic              pin_oe;
    logic [1:0]        ftype;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // master clock cycles per conversion for a given setup
  function automatic logic [20:0] period_mclk(input logic [15:0] fc);
    logic [20:0] p;
    logic [1:0]  ty;
    p  = '0;
    ty = fc[FC_TYPE_LSB +: 2];
    if (fc[FC_DIRECT_BIT]) begin
      // mclk = 2 * modulator clocks; 32 modulator clocks per count
      p = 21'(MOD_DIV * DIRECT_MULT) * 21'(fc[14:0]);
    end else if (ty == FILT_SINC5_SINC1) begin
      // sinc5 fixed, sinc1 decimates by 2^rate
      p = 21'(SINC5_MCLK) << fc[FC_RATE_LSB +: 4];
    end else begin
      p = 21'(SINC5_MCLK) << (fc[FC_RATE_LSB +: 4] + 4'h1);
    end
    if (p == '0) begin
      p = 21'(SINC5_MCLK);
    end
    return p;
  endfunction

  // conversions needed for a settled result
  function automatic logic [1:0] settle_periods(input logic [15:0] fc);
    logic [1:0] n;
    n = 2'(SINC3_SETTLE_N);
    if (!fc[FC_DIRECT_BIT] && fc[FC_TYPE_LSB +: 2] == FILT_SINC5_SINC1) begin
      // one conversion at 10 kSPS or lower
      n = ((21'h1 << fc[FC_RATE_LSB +: 4]) >= 21'(SINC1_SETTLE_MIN)) ? 2'h1 : 2'h2;
    end
    return n;
  endfunction

  logic [15:0] fc_sel;
  logic        mclk_edge;
  logic        ext_rise;
  logic        xtal_rise;
  logic        osc_rise;
  logic [1:0]  need;

  always_comb begin
    st_nxt = st_r;
    // three-stage synchronisers; act once stages two and three agree
    st_nxt.ext_sync  = {st_r.ext_sync[1:0], clock_io_pin_i};
    st_nxt.xtal_sync = {st_r.xtal_sync[1:0], crystal_input_pin_i};
    if (st_r.ext_sync[2] == st_r.ext_sync[1]) begin
      st_nxt.ext_lvl = st_r.ext_sync[2];
    end
    if (st_r.xtal_sync[2] == st_r.xtal_sync[1]) begin
      st_nxt.xtal_lvl = st_r.xtal_sync[2];
    end
    ext_rise  = st_nxt.ext_lvl & ~st_r.ext_lvl;
    xtal_rise = st_nxt.xtal_lvl & ~st_r.xtal_lvl;

    // internal oscillator model from the system clock
    osc_rise = 1'b0;
    if (st_r.osc_cnt == 8'(OSC_HALF_CYC - 1)) begin
      st_nxt.osc_cnt = '0;
      st_nxt.osc_clk = ~st_r.osc_clk;
      osc_rise       = ~st_r.osc_clk;
    end else begin
      st_nxt.osc_cnt = st_r.osc_cnt + 8'h1;
    end

    // source mux for master clock edge
    case (st_r.clk_src)
      CLK_SRC_INT:     mclk_edge = osc_rise;
      CLK_SRC_INT_OUT: mclk_edge = osc_rise;
      CLK_SRC_EXT:     mclk_edge = ext_rise;
      CLK_SRC_XTAL:    mclk_edge = xtal_rise;
      default:         mclk_edge = osc_rise;
    endcase
    st_nxt.pin_oe  = (st_r.clk_src == CLK_SRC_INT_OUT);
    st_nxt.pin_out = st_nxt.pin_oe & st_r.osc_clk;

    fc_sel = st_r.chan ? st_r.filter_config1 : st_r.filter_config0;
    need   = settle_periods(fc_sel);

    st_nxt.ready = 1'b0;
    if (mclk_edge) begin
      st_nxt.mclk_div = ~st_r.mclk_div;
      st_nxt.mod_clk  = ~st_r.mclk_div;
      // rates count master edges, so they scale with the source
      if (st_r.mclk_cnt >= period_mclk(fc_sel) - 21'h1) begin
        st_nxt.mclk_cnt = '0;
        if (!st_r.settle_once_mode || need == 2'h1 || st_r.settle_cnt >= need - 2'h1) begin
          // full-rate output; in settle-once only settled ones
          st_nxt.settle_cnt = '0;
          st_nxt.ready      = 1'b1;
          st_nxt.data       = sample_i;
        end else begin
          st_nxt.settle_cnt = st_r.settle_cnt + 2'h1;
        end
      end else begin
        st_nxt.mclk_cnt = st_r.mclk_cnt + 21'h1;
      end
    end

    // sticky status, set wins over clear
    if (bus_i.wr && bus_i.addr == ADDR_STATUS) begin
      st_nxt.status = st_r.status & ~bus_i.wdata[1:0];
    end
    if (st_nxt.ready) begin
      st_nxt.status[ST_RDY_BIT] = 1'b1;
    end
    if (ext_rise && st_r.clk_src == CLK_SRC_EXT) begin
      st_nxt.status[ST_SRC_BIT] = 1'b1;
    end

    if (bus_i.wr) begin
      case (bus_i.addr)
        ADDR_MODE: begin
          st_nxt.clk_src          = bus_i.wdata[MODE_CLK_LSB +: 2];
          st_nxt.settle_once_mode = bus_i.wdata[MODE_SETTLE_BIT];
        end
        ADDR_FC0: st_nxt.filter_config0 = bus_i.wdata;
        ADDR_FC1: st_nxt.filter_config1 = bus_i.wdata;
        ADDR_CHAN: st_nxt.chan = bus_i.wdata[0];
        ADDR_MASK: st_nxt.mask = bus_i.wdata[1:0];
        default: st_nxt.mask = st_r.mask;
      endcase
      // new setup or source restarts the conversion, no stale short period
      if (bus_i.addr == ADDR_MODE || bus_i.addr == ADDR_FC0 ||
          bus_i.addr == ADDR_FC1 || bus_i.addr == ADDR_CHAN) begin
        st_nxt.mclk_cnt   = '0;
        st_nxt.settle_cnt = '0;
      end
    end
    // effective type of setup 0, registered
    st_nxt.ftype = st_nxt.filter_config0[FC_DIRECT_BIT] ? FILT_SINC3
                   : st_nxt.filter_config0[FC_TYPE_LSB +: 2];

    st_nxt.rdata = '0;
    if (bus_i.rd) begin
      case (bus_i.addr)
        ADDR_MODE: begin
          st_nxt.rdata[MODE_CLK_LSB +: 2]  = st_r.clk_src;
          st_nxt.rdata[MODE_SETTLE_BIT]    = st_r.settle_once_mode;
        end
        ADDR_FC0:    st_nxt.rdata = st_r.filter_config0;
        ADDR_FC1:    st_nxt.rdata = st_r.filter_config1;
        ADDR_CHAN:   st_nxt.rdata = {15'h0000, st_r.chan};
        ADDR_STATUS: st_nxt.rdata = {14'h0000, st_r.status};
        ADDR_MASK:   st_nxt.rdata = {14'h0000, st_r.mask};
        ADDR_DATA:   st_nxt.rdata = st_r.data[DATA_W-1 -: 16];
        ADDR_INFO:   st_nxt.rdata = {st_r.settle_cnt, fc_sel[FC_TYPE_LSB +: 2], 12'h000};
        default:     st_nxt.rdata = '0;
      endcase
    end
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r                <= '0;
      st_r.clk_src        <= CLK_SRC_RST;
      st_r.filter_config0 <= FC_RST;
      st_r.filter_config1 <= FC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o           = st_r.rdata;
  assign clock_io_pin_o    = st_r.pin_out;
  assign clock_io_pin_oe_o = st_r.pin_oe;
  assign modulator_rate_o  = st_r.mod_clk;
  assign filter_type_o     = st_r.ftype;
  assign data_ready_o      = st_r.ready;
  assign data_o            = st_r.data;
  assign irq_o             = st_r.irq;
endmodule

/* tb/clk_filt_ctrl_props.sv */
// concurrent checks on the clock and filter control block ports
`timescale 1ns/1ps
module clk_filt_ctrl_props
  import clk_filt_pkg::*;
#(
  parameter int unsigned DATA_W = 24
) (
  input  wire logic                   clock_i,
  input  wire logic                   arst_n_i,
  input  wire clk_filt_pkg::bus_req_t bus_i,
  input  wire logic [15:0]            rdata_o,
  input  wire logic                   clock_io_pin_oe_o,
  input  wire logic                   modulator_rate_o,
  input  wire logic [1:0]             filter_type_o,
  input  wire logic                   data_ready_o,
  input  wire logic [DATA_W-1:0]      data_o
);
  logic [11:0] gap_r;
  logic [1:0]  ftype_w;
  logic        fc0_wr;
  assign ftype_w = bus_i.wdata[6:5];
  assign fc0_wr = bus_i.wr && bus_i.addr == ADDR_FC0;
  // cycles since last result, saturating
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) gap_r <= '1;
    else if (data_ready_o) gap_r <= '0;
    else if (gap_r != '1) gap_r <= gap_r + 12'h001;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  property p_oe_on;
    bus_i.wr && bus_i.addr == ADDR_MODE && bus_i.wdata[3:2] == CLK_SRC_INT_OUT
      |-> ##[1:4] clock_io_pin_oe_o;
  endproperty
  property p_oe_off;
    bus_i.wr && bus_i.addr == ADDR_MODE && bus_i.wdata[3:2] != CLK_SRC_INT_OUT
      |-> ##[1:4] !clock_io_pin_oe_o;
  endproperty
  property p_rdata_idle; !$past(bus_i.rd) |-> rdata_o == 16'h0000; endproperty
  property p_rdy_pulse; data_ready_o |=> !data_ready_o; endproperty
  property p_data_hold; $changed(data_o) |-> data_ready_o; endproperty
  property p_direct; fc0_wr && bus_i.wdata[15] |=> filter_type_o == FILT_SINC3; endproperty
  property p_type; fc0_wr && !bus_i.wdata[15] |=> filter_type_o == $past(ftype_w); endproperty
  property p_mod; $changed(modulator_rate_o) |=> $stable(modulator_rate_o)[*6]; endproperty
  property p_gap; data_ready_o |-> gap_r >= 12'h190; endproperty
  a_oe_on:      assert property (p_oe_on) else $error("clock out not enabled");
  a_oe_off:     assert property (p_oe_off) else $error("clock out still on");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  a_rdy_pulse:  assert property (p_rdy_pulse) else $error("ready longer than one cycle");
  a_data_hold:  assert property (p_data_hold) else $error("data moved without ready");
  a_direct:     assert property (p_direct) else $error("direct mode type wrong");
  a_type:       assert property (p_type) else $error("filter type wrong");
  a_mod:        assert property (p_mod) else $error("modulator too fast");
  a_gap:        assert property (p_gap) else $error("results too close");
  c_rdy:  cover property (data_ready_o);
  c_oe:   cover property (clock_io_pin_oe_o);
  c_sinc3: cover property (filter_type_o == FILT_SINC3);
endmodule
bind clk_filt_ctrl clk_filt_ctrl_props #(.DATA_W(DATA_W)) u_clk_filt_ctrl_props (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .clock_io_pin_oe_o(clock_io_pin_oe_o), .modulator_rate_o(modulator_rate_o),
  .filter_type_o(filter_type_o), .data_ready_o(data_ready_o), .data_o(data_o));

/* tb/clk_src_model.sv */
// far-side clock sources: external clock and crystal level
`timescale 1ns/1ps
module clk_src_model (
  input  wire logic run_i,
  output logic      ext_clk_o,
  output logic      xtal_o
);
  initial ext_clk_o = 1'b0;
  // toggles only while run, else stands low
  always #16 ext_clk_o = run_i ? ~ext_clk_o : 1'b0;
  // crystal quiet until run, so no double edges
  assign xtal_o = ext_clk_o;
endmodule

/* tb/test_adc_clock_and_filter_control.sv */
// bench for the clock and filter control block
`timescale 1ns/1ps
module test_adc_clock_and_filter_control;
  import clk_filt_pkg::*;
  logic clock_i = 1'b0;
  logic arst_n_i, run, ext, xtal, pin_o, oe, mod, rdy, irq;
  wire  pin;
  bus_req_t bus_i;
  logic [15:0] rdata_o, v;
  logic [23:0] sample_r, data;
  logic [1:0] ftype;
  int failures = 0, comparisons = 0, cyc = 0, n;
  logic [15:0] t_mode [6] = '{16'h0008, 16'h0008, 16'h0018, 16'h0018, 16'h0008, 16'h000c};
  logic [15:0] t_fc0 [6] = '{16'h0000, 16'h8002, 16'h0060, 16'h0003, 16'h0000, 16'h0000};
  int t_ch [6] = '{0, 0, 0, 0, 1, 0};
  int t_exp [6] = '{512, 1024, 3072, 8192, 1024, 512};
  always #2 clock_i = ~clock_i;
  assign pin = oe ? pin_o : ext;
  clk_src_model u_clk_src_model (.run_i(run), .ext_clk_o(ext), .xtal_o(xtal));
  clk_filt_ctrl u_clk_filt_ctrl (.clock_i(clock_i), .arst_n_i(arst_n_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .clock_io_pin_i(pin), .clock_io_pin_o(pin_o),
    .clock_io_pin_oe_o(oe), .crystal_input_pin_i(xtal), .sample_i(sample_r),
    .modulator_rate_o(mod), .filter_type_o(ftype), .data_ready_o(rdy), .data_o(data),
    .irq_o(irq));
  always @(posedge clock_i) sample_r <= sample_r + 24'h000001;
  task automatic test_done;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    bus_i <= '0;
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    bus_i <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    bus_i <= '0;
    #1 d = rdata_o;
    @(posedge clock_i);
  endtask
  task automatic wait_rdy(output int k);
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (rdy !== 1'b1 && k < 20000);
  endtask
  initial begin
    bus_i = '0;
    run = 1'b0;
    arst_n_i = 1'b0;
    sample_r = 24'h000000;
    repeat (12) @(posedge clock_i);
    arst_n_i <= 1'b1;
    @(posedge clock_i);
    rd(ADDR_MODE, v);
    chk("mode_rst", 16'h0000, v);
    chk("oe_rst", 16'h0000, {15'h0000, oe});
    wr(ADDR_MODE, 16'h0004);
    repeat (4) @(posedge clock_i);
    chk("oe_drive", 16'h0001, {15'h0000, oe});
    v = {15'h0000, pin_o};
    repeat (7) @(posedge clock_i);
    chk("pin_toggle", {15'h0000, ~v[0]}, {15'h0000, pin_o});
    wr(ADDR_FC0, 16'h0060);
    chk("type_sinc3", 16'h0003, {14'h0000, ftype});
    wr(ADDR_FC0, 16'h0040);
    chk("type_enh", 16'h0002, {14'h0000, ftype});
    wr(ADDR_FC0, 16'h8045);
    chk("type_direct", 16'h0003, {14'h0000, ftype});
    rd(4'h9, v);
    chk("unmapped", 16'h0000, v);
    run <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_MODE, t_mode[i]);
      wr(ADDR_FC0, t_fc0[i]);
      wr(ADDR_FC1, 16'h0001);
      wr(ADDR_CHAN, t_ch[i][15:0]);
      wait_rdy(n);
      wait_rdy(n);
      wait_rdy(n);
      comparisons++;
      if (n > t_exp[i] + 4 || n + 4 < t_exp[i]) begin
        failures++;
        $display("[ERR] period %0d expected %0d seen %0d", i, t_exp[i], n);
      end
    end
    wr(ADDR_MASK, 16'h0001);
    wait_rdy(n);
    repeat (3) @(posedge clock_i);
    chk("irq_set", 16'h0001, {15'h0000, irq});
    rd(ADDR_STATUS, v);
    chk("status_rdy", 16'h0001, {15'h0000, v[0]});
    wr(ADDR_STATUS, 16'h0003);
    @(posedge clock_i);
    chk("irq_clr", 16'h0000, {15'h0000, irq});
    wr(ADDR_MASK, 16'h0000);
    wait_rdy(n);
    repeat (3) @(posedge clock_i);
    chk("irq_mask", 16'h0000, {15'h0000, irq});
    test_done();
  end
endmodule
